// ### verilog/css_pkg.sv
/*
 * Package for the card socket status register: register offset, bit
 * positions, reset values and the card pin bundle type.
 * Assumes a single host clock domain; card pins are asynchronous to it.
 */
package css_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] CSS_STATUS_OFFSET = 12'h801;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CSS_BIT_RSVD7  = 7;
  localparam int CSS_BIT_POWER  = 6;
  localparam int CSS_BIT_READY  = 5;
  localparam int CSS_BIT_WLOCK  = 4;
  localparam int CSS_BIT_SEAT2  = 3;
  localparam int CSS_BIT_SEAT1  = 2;
  localparam int CSS_BIT_FIELD1 = 1;
  localparam int CSS_BIT_FIELD0 = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] CSS_READ_RESET = 8'h00;
  localparam logic [2:0] CSS_SYNC_RESET = 3'h0;

  // Card pins as one bundle
  typedef struct packed {
    logic ready;
    logic write_lock;
    logic seat_sense_pin_2_n;
    logic seat_sense_pin_1_n;
    logic battery_sense_2;
    logic battery_sense_1;
    logic audio_out_pin;
    logic status_change_pin;
  } css_pins_t;

endpackage

// ### verilog/css_status_reg.sv
/*
 * Socket status register: read-only byte reporting live card socket state.
 * Assumes host reads by address with a read strobe, one clock, and that
 * the card pins are asynchronous and must be synchronised here.
 */
// Functional notes
// - Bit 7 always reads zero; writes to it are ignored.
// - Bit 6 shows socket power, following power control programming.
// - Bit 5 shows the card ready line level.
// - Bit 4 equals the write-lock pin; one means read-only.
// - Bit 3 reads one when seat-sense pin 2 is low.
// - Bit 2 reads one when seat-sense pin 1 is low.
// - Memory card: bit 0 battery sense 1, bit 1 battery sense 2.
// - I/O card: bit 1 audio out, bit 0 status change, unencoded.
// - After reset bit 7 reads zero, bit 6 follows i_power_on, lower bits show the cleared synchroniser (bits 3:2 one) until the lines pass through it.
// - Register is read-only; host writes change nothing.
`timescale 1ns/1ps
module css_status_reg
  import css_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_reset_n,
  input  wire logic [11:0] i_addr,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_power_on,
  input  wire logic        i_io_card,
  input  wire css_pins_t   i_pins,
  output logic [7:0]       o_rdata,
  output logic             o_rvalid
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Three stages; a change counts once stages two and three agree,
  // which rejects a single-cycle glitch leaking past stage one.
  css_pins_t sync1_q, sync2_q, sync3_q, live_q;
  css_pins_t sync1_d, sync2_d, sync3_d, live_d;

  always_comb begin
    sync1_d = i_pins;
    sync2_d = sync1_q;
    sync3_d = sync2_q;
    live_d  = live_q;
    if (sync2_q == sync3_q) begin
      live_d = sync3_q;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1_q <= css_pins_t'(CSS_READ_RESET);
      sync2_q <= css_pins_t'(CSS_READ_RESET);
      sync3_q <= css_pins_t'(CSS_READ_RESET);
      live_q  <= css_pins_t'(CSS_READ_RESET);
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      sync3_q <= sync3_d;
      live_q  <= live_d;
    end
  end

  // ****************************************************************
  // Status byte and read port
  // ****************************************************************
  logic [7:0] status;
  logic [7:0] rdata_q, rdata_d;
  logic       rvalid_q, rvalid_d;

  // Live composition; power and card type come from same-clock logic
  always_comb begin
    status                 = 8'h00;
    status[CSS_BIT_RSVD7]  = 1'b0;
    status[CSS_BIT_POWER]  = i_power_on;
    status[CSS_BIT_READY]  = live_q.ready;
    status[CSS_BIT_WLOCK]  = live_q.write_lock;
    status[CSS_BIT_SEAT2]  = ~live_q.seat_sense_pin_2_n;
    status[CSS_BIT_SEAT1]  = ~live_q.seat_sense_pin_1_n;
    if (i_io_card) begin
      status[CSS_BIT_FIELD1] = live_q.audio_out_pin;
      status[CSS_BIT_FIELD0] = live_q.status_change_pin;
    end else begin
      status[CSS_BIT_FIELD1] = live_q.battery_sense_2;
      status[CSS_BIT_FIELD0] = live_q.battery_sense_1;
    end
  end

  // Writes are decoded nowhere, so nothing can alter the byte
  always_comb begin
    rdata_d  = CSS_READ_RESET;
    rvalid_d = 1'b0;
    if (i_read && (i_addr == CSS_STATUS_OFFSET)) begin
      rdata_d  = status;
      rvalid_d = 1'b1;
    end else if (i_read) begin
      rvalid_d = 1'b1;                                     // Unmapped reads as zero
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_q  <= CSS_READ_RESET;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign o_rdata  = rdata_q;
  assign o_rvalid = rvalid_q;

  // Write port kept for bus completeness; ignored by design
  logic unused_write;
  assign unused_write = i_write ^ (^i_wdata);

endmodule

// ### verification/css_status_reg_monitor.sv
/* Port checker; one clock, async reset. */
`timescale 1ns/1ps
module css_status_reg_monitor import css_pkg::*; (
  input wire logic i_clock, i_reset_n, i_read, i_write, i_power_on, i_io_card, o_rvalid,
  input wire logic [11:0] i_addr,
  input wire logic [7:0] o_rdata,
  input wire css_pins_t i_pins
);
  wire hit = i_read && i_addr == CSS_STATUS_OFFSET;
  wire [5:0] view = {i_pins[7:6], ~i_pins[5:4], i_io_card ? i_pins[1:0] : i_pins[3:2]};
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // Pins held past the synchroniser delay
  a_pin_view: assert property ($stable(i_pins) [*6] ##1 hit |=>
    o_rdata[5:0] == $past(view)) else $error("pins");
  a_read_ack: assert property (i_read |=> o_rvalid) else $error("ack");
  a_no_stray: assert property (!i_read |=> !o_rvalid) else $error("ack");
  a_bit7_zero: assert property (o_rvalid |-> !o_rdata[7]) else $error("b7");
  a_power_bit: assert property (hit |=> o_rdata[6] == $past(i_power_on)) else $error("b6");
  a_idle_zero: assert property (!o_rvalid |-> !o_rdata) else $error("dat");
  a_write_void: assert property (i_write && !i_read |=> !o_rdata) else $error("wr");
  a_reset_upper: assert property ($rose(i_reset_n) |-> !o_rdata[7:6]) else $error("rst");
endmodule
bind css_status_reg css_status_reg_monitor u_css_status_reg_monitor (.*);

// ### verification/css_card_model.sv
/* Card model; the bench sets seat, type and levels. */
`timescale 1ns/1ps
module css_card_model (input wire logic i_in, i_io, input wire logic [3:0] i_lv, output css_pkg::css_pins_t o_pins);
  // Unused pin pair inverted so a wrong view never matches
  assign o_pins = {i_lv[3:2], {2{~i_in}}, i_lv[1:0] ^ {2{i_io}}, i_lv[1:0] ^ {2{~i_io}}};
endmodule

// ### verification/css_status_reg_bench.sv
/* Bench; a card model drives the pins. */
`timescale 1ns/1ps
module css_status_reg_bench import css_pkg::*;;
  logic i_clock = 0, i_reset_n = 0, i_read = 0, i_write = 0, i_power_on = 0, i_io_card = 0, p = 0, o_rvalid;
  logic [11:0] i_addr = CSS_STATUS_OFFSET;
  logic [7:0] i_wdata = 8'hFF, o_rdata;
  logic [3:0] l = 4'h0;
  css_pins_t i_pins;
  int miscompares = 0, samples_checked = 0;
  css_card_model u_css_card_model (.i_in(p), .i_io(i_io_card), .i_lv(l), .o_pins(i_pins));
  css_status_reg u_css_status_reg (.*);
  initial forever #2 i_clock = ~i_clock;
  task automatic chk(input logic [7:0] s, e);
    samples_checked++;
    miscompares += (s !== e);
    if (s !== e) $display("[FAIL] %0t %h %h", $time, s, e);
  endtask
  task automatic tally_and_finish(input int hung);
    miscompares += hung;
    $display("%0d checks %0d mismatches", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial #20000 tally_and_finish(1);
  // Every mix of power, seat, card type and lines, writes interleaved
  initial begin
    repeat (4) @(posedge i_clock);
    #1 i_reset_n = 1;
    for (int i = 0; i < 128; i++) begin
      {i_write, i_io_card, i_power_on, p, l} = {i[0], i[6:0]};
      repeat (8) @(posedge i_clock);
      #1 i_read = 1;
      @(posedge i_clock) #1 i_read = 0;
      chk(o_rdata, {1'h0, i_power_on, l[3:2], p, p, l[1:0]});
      chk({7'h00, o_rvalid}, 8'h01);
      @(posedge i_clock) #1 chk({o_rvalid, o_rdata[6:0]}, 8'h00);
    end
    // Unmapped address answers zero but still acknowledges
    i_addr = 12'h802;
    i_read = 1;
    @(posedge i_clock) #1 i_read = 0;
    chk(o_rdata, 8'h00);
    chk({7'h00, o_rvalid}, 8'h01);
    @(posedge i_clock) #1;
    tally_and_finish(0);
  end
endmodule
